// *** pac_div.sv ***
// Free-running divider producing a one-cycle enable pulse every DIV cycles.
// Assumes a single clock domain.
`timescale 1ns/1ps
module pac_div #(
  parameter int DIV = 64
) (
  input wire logic i_clock,
  input wire logic i_rst,
  output logic o_tick
);

  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_reg;

  // Runs free regardless of mode so the gated time base never restarts
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_reg == LAST);
      if (cnt_reg == LAST) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule : pac_div

// *** pac_pin_src.sv ***
// Pin source model driving the accumulator input pin.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
module pac_pin_src (
  input wire logic i_clock,
  output logic o_pin
);
  // Pin idles low, as a pulled-down line would
  initial o_pin = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Hold a level for n cycles; the change lands just after an edge
  task automatic hold(input logic v, input int n);
    @(posedge i_clock);
    o_pin <= v;
    repeat (n) @(posedge i_clock);
  endtask : hold

  // One pulse; widths kept well above the short-pulse loss of the filter
  task automatic pulse(input int hi, input int lo);
    hold(1'b1, hi);
    hold(1'b0, lo);
  endtask : pulse
endmodule : pac_pin_src

// *** pac_pkg.sv ***
// Package for the pulse accumulator: register map, field positions, reset
// values and timing counts.
// Assumes an 8-bit register port on a single 125 MHz clock.
package pac_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] PAC_OFS_MASK = 8'h24;
  localparam logic [7:0] PAC_OFS_FLAG = 8'h25;
  localparam logic [7:0] PAC_OFS_CTRL = 8'h26;
  localparam logic [7:0] PAC_OFS_COUNT = 8'h27;

  // Field positions shared by mask and flag registers
  localparam int PAC_BIT_OVF = 5;
  localparam int PAC_BIT_EDGE = 4;

  // Field positions of the control register
  localparam int PAC_BIT_ENABLE = 6;
  localparam int PAC_BIT_MODE = 5;
  localparam int PAC_BIT_EDGESEL = 4;

  // Reset values
  localparam logic [7:0] PAC_RST_MASK = 8'h00;
  localparam logic [7:0] PAC_RST_FLAG = 8'h00;
  localparam logic [7:0] PAC_RST_CTRL = 8'h00;
  localparam logic [7:0] PAC_RST_COUNT = 8'h00;

  // Gated time base: bus clock divided by this figure
  localparam int PAC_GATE_DIV = 64;

  // Counter width
  localparam int PAC_COUNT_W = 8;

endpackage : pac_pkg

// *** pac_sync.sv ***
// Three-stage input synchroniser with agreement of the last two stages.
// Assumes the input is asynchronous to i_clock.
`timescale 1ns/1ps
module pac_sync (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level
);

  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  // First stage feeds only the second; level moves once two and three agree
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_level <= 1'b0;
    end else begin
      meta_reg <= i_async;
      s2_reg <= meta_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        o_level <= s3_reg;
      end
    end
  end

endmodule : pac_sync

// *** pac_top.sv ***
// Pulse accumulator: 8-bit event counter or gated time accumulator with
// overflow and input-edge flags, mask register and one interrupt output.
// Assumes a register master on i_clock and an asynchronous input pin.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// - 8-bit counter, event or gated-time mode
// - Count readable and writable at any time
// - Event mode: pin edges advance the count
// - Gated mode: pin gates bus clock over 64
// - Overflow flag with mask bit 5 interrupts
// - Edge flag with mask bit 4 interrupts
// - Mask bits pair with same flag bits
// - Overflow flag set on roll to zero
// - Edge flag set on selected active edge
// - Write one clears only that flag
// - Mode and edge bits pick edge or level
module pac_top
  import pac_pkg::*;
#(
  parameter int GATE_DIV = PAC_GATE_DIV
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_accum_input_pin,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] timer_irq_mask_two_reg;
  logic [7:0] timer_irq_flag_two_reg;
  logic [7:0] ctrl_reg;
  logic [PAC_COUNT_W-1:0] accum_count_value_reg;
  logic [PAC_COUNT_W-1:0] count_next;
  logic accum_input;
  logic accum_input_prev_reg;
  logic gate_tick;
  logic accum_enable;
  logic accum_mode_sel;
  logic accum_edge_sel;
  logic edge_active;
  logic count_step;
  logic ovf_event;
  logic edge_event;
  logic wr_mask;
  logic wr_flag;
  logic wr_ctrl;
  logic wr_count;
  logic [7:0] flag_next;
  logic [7:0] mask_next;

  ////////////////////////////////////////////////////////////////////////
  // Input conditioning and time base

  pac_sync u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_async(i_accum_input_pin),
    .o_level(accum_input)
  );

  pac_div #(
    .DIV(GATE_DIV)
  ) u_div (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .o_tick(gate_tick)
  );

  // Previous filtered level for edge detection
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      accum_input_prev_reg <= 1'b0;
    end else begin
      accum_input_prev_reg <= accum_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counting

  assign accum_enable = ctrl_reg[PAC_BIT_ENABLE];
  assign accum_mode_sel = ctrl_reg[PAC_BIT_MODE];
  assign accum_edge_sel = ctrl_reg[PAC_BIT_EDGESEL];

  // Selected edge: edge 0 falling, edge 1 rising, in both modes
  assign edge_active = accum_edge_sel ? (accum_input & ~accum_input_prev_reg)
                                      : (~accum_input & accum_input_prev_reg);

  // Event mode counts edges; gated mode counts ticks unless the pin
  // shows the inhibiting level (edge bit equal to the pin level)
  always_comb begin
    count_step = 1'b0;
    if (accum_enable) begin
      if (!accum_mode_sel) begin
        count_step = edge_active;
      end else begin
        count_step = gate_tick & (accum_input != accum_edge_sel);
      end
    end
  end

  assign count_next = accum_count_value_reg + 1'b1;
  assign ovf_event = count_step & (accum_count_value_reg == {PAC_COUNT_W{1'b1}});
  assign edge_event = accum_enable & edge_active;

  // A software write wins over a same-cycle step so the written value sticks
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      accum_count_value_reg <= PAC_RST_COUNT;
    end else if (wr_count) begin
      accum_count_value_reg <= i_wdata;
    end else if (count_step) begin
      accum_count_value_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  assign wr_mask = i_wr & (i_addr == PAC_OFS_MASK);
  assign wr_flag = i_wr & (i_addr == PAC_OFS_FLAG);
  assign wr_ctrl = i_wr & (i_addr == PAC_OFS_CTRL);
  assign wr_count = i_wr & (i_addr == PAC_OFS_COUNT);

  // Only the two accumulator bits exist in the mask and flag registers
  localparam logic [7:0] flag_impl = 8'h30;

  // Mask register; its next value also feeds the interrupt register
  assign mask_next = wr_mask ? (i_wdata & flag_impl) : timer_irq_mask_two_reg;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      timer_irq_mask_two_reg <= PAC_RST_MASK;
    end else begin
      timer_irq_mask_two_reg <= mask_next;
    end
  end

  // Control register
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= PAC_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_reg <= i_wdata & 8'h70;
    end
  end

  // Flags: write one clears, a set in the same cycle wins
  always_comb begin
    flag_next = timer_irq_flag_two_reg;
    if (wr_flag) begin
      flag_next = flag_next & ~(i_wdata & flag_impl);
    end
    if (ovf_event) begin
      flag_next[PAC_BIT_OVF] = 1'b1;
    end
    if (edge_event) begin
      flag_next[PAC_BIT_EDGE] = 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      timer_irq_flag_two_reg <= PAC_RST_FLAG;
    end else begin
      timer_irq_flag_two_reg <= flag_next;
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        PAC_OFS_MASK: o_rdata <= timer_irq_mask_two_reg;
        PAC_OFS_FLAG: o_rdata <= timer_irq_flag_two_reg;
        PAC_OFS_CTRL: o_rdata <= ctrl_reg;
        PAC_OFS_COUNT: o_rdata <= accum_count_value_reg;
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt

  // Registered from next flag and mask state so a mask write shows at once
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(flag_next & mask_next);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  AST_OVF_IRQ: assert property (@(posedge i_clock) disable iff (i_rst)
    (timer_irq_flag_two_reg[PAC_BIT_OVF] && timer_irq_mask_two_reg[PAC_BIT_OVF]) |-> o_irq)
    else $error("overflow flag enabled but no interrupt");

  AST_EDGE_IRQ: assert property (@(posedge i_clock) disable iff (i_rst)
    (timer_irq_flag_two_reg[PAC_BIT_EDGE] && timer_irq_mask_two_reg[PAC_BIT_EDGE]) |-> o_irq)
    else $error("edge flag enabled but no interrupt");

  AST_MASKED_QUIET: assert property (@(posedge i_clock) disable iff (i_rst)
    ((timer_irq_flag_two_reg & timer_irq_mask_two_reg) == 8'h00) |-> !o_irq)
    else $error("interrupt with no enabled flag");

  AST_OVF_SET: assert property (@(posedge i_clock) disable iff (i_rst)
    (count_step && !wr_count && accum_count_value_reg == 8'hff)
      |=> (accum_count_value_reg == 8'h00) && timer_irq_flag_two_reg[PAC_BIT_OVF])
    else $error("rollover did not set overflow flag");

  AST_EDGE_SET: assert property (@(posedge i_clock) disable iff (i_rst)
    edge_event |=> timer_irq_flag_two_reg[PAC_BIT_EDGE])
    else $error("edge flag not set");

  AST_W1C: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_flag && !i_wdata[PAC_BIT_EDGE] && timer_irq_flag_two_reg[PAC_BIT_EDGE])
      |=> timer_irq_flag_two_reg[PAC_BIT_EDGE])
    else $error("flag cleared without a one written");

  AST_HOLD_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
    (!accum_enable && !wr_count) |=> $stable(accum_count_value_reg))
    else $error("count moved while disabled");

  AST_WRITE_COUNT: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_count |=> (accum_count_value_reg == $past(i_wdata)))
    else $error("count write lost");

  AST_GATED_INHIBIT: assert property (@(posedge i_clock) disable iff (i_rst)
    (accum_mode_sel && accum_input == accum_edge_sel && !wr_count)
      |=> $stable(accum_count_value_reg))
    else $error("gated count advanced while inhibited");

  AST_EVENT_STEP: assert property (@(posedge i_clock) disable iff (i_rst)
    (accum_enable && !accum_mode_sel && edge_active && !wr_count)
      |=> (accum_count_value_reg == $past(count_next)))
    else $error("event edge did not advance count");

  AST_GATED_RATE: assert property (@(posedge i_clock) disable iff (i_rst)
    gate_tick |=> !gate_tick [*7])
    else $error("gate ticks too close");

  // Cycles since the last gate tick; a repetition count cannot span a
  // full gate period, so the spacing is checked on this counter instead
  logic [15:0] tick_gap_reg;
  logic tick_seen_reg;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tick_gap_reg <= 16'h0000;
      tick_seen_reg <= 1'b0;
    end else if (gate_tick) begin
      tick_gap_reg <= 16'h0001;
      tick_seen_reg <= 1'b1;
    end else if (tick_gap_reg != 16'hffff) begin
      tick_gap_reg <= tick_gap_reg + 16'h0001;
    end
  end

  AST_TICK_SPACING: assert property (@(posedge i_clock) disable iff (i_rst)
    (gate_tick && tick_seen_reg) |-> (tick_gap_reg == 16'(GATE_DIV)))
    else $error("gate tick spacing wrong");

  AST_TICK_DUE: assert property (@(posedge i_clock) disable iff (i_rst)
    (tick_seen_reg && tick_gap_reg == 16'(GATE_DIV)) |-> gate_tick)
    else $error("gate tick missing");

  AST_GATED_STEP: assert property (@(posedge i_clock) disable iff (i_rst)
    (accum_enable && accum_mode_sel && gate_tick && accum_input != accum_edge_sel && !wr_count)
      |=> (accum_count_value_reg == $past(count_next)))
    else $error("gated tick did not advance count");

  AST_IRQ_LEVEL: assert property (@(posedge i_clock) disable iff (i_rst)
    o_irq == |(timer_irq_flag_two_reg & timer_irq_mask_two_reg))
    else $error("interrupt does not follow flags and mask");

  AST_OVF_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_flag && i_wdata[PAC_BIT_OVF] && !ovf_event)
      |=> !timer_irq_flag_two_reg[PAC_BIT_OVF])
    else $error("overflow flag not cleared by write of one");

  AST_EDGE_CLEAR: assert property (@(posedge i_clock) disable iff (i_rst)
    (wr_flag && i_wdata[PAC_BIT_EDGE] && !edge_event)
      |=> !timer_irq_flag_two_reg[PAC_BIT_EDGE])
    else $error("edge flag not cleared by write of one");

  AST_OVF_ONLY: assert property (@(posedge i_clock) disable iff (i_rst)
    (!ovf_event && !timer_irq_flag_two_reg[PAC_BIT_OVF])
      |=> !timer_irq_flag_two_reg[PAC_BIT_OVF])
    else $error("overflow flag set with no rollover");

  AST_EDGE_ONLY: assert property (@(posedge i_clock) disable iff (i_rst)
    (!edge_event && !timer_irq_flag_two_reg[PAC_BIT_EDGE])
      |=> !timer_irq_flag_two_reg[PAC_BIT_EDGE])
    else $error("edge flag set with no edge");

  AST_OFF_NO_FLAG: assert property (@(posedge i_clock) disable iff (i_rst)
    !accum_enable
      |=> ((timer_irq_flag_two_reg & ~$past(timer_irq_flag_two_reg)) == 8'h00))
    else $error("flag set while disabled");

  AST_UNIMPL_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
    ((timer_irq_flag_two_reg | timer_irq_mask_two_reg) & ~flag_impl) == 8'h00)
    else $error("unimplemented mask or flag bit set");

  AST_READ_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
    !i_rd |=> (o_rdata == 8'h00))
    else $error("read data not zero outside a read");

  AST_READ_COUNT: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_rd && i_addr == PAC_OFS_COUNT)
      |=> (o_rdata == $past(accum_count_value_reg)))
    else $error("count read returned wrong value");

  AST_READ_MASK: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_rd && i_addr == PAC_OFS_MASK)
      |=> (o_rdata == $past(timer_irq_mask_two_reg)))
    else $error("mask read returned wrong value");

  AST_READ_FLAG: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_rd && i_addr == PAC_OFS_FLAG) |=> (o_rdata == $past(timer_irq_flag_two_reg)))
    else $error("flag read returned wrong value");

  COV_ROLL: cover property (@(posedge i_clock) disable iff (i_rst) ovf_event);
  COV_EDGE: cover property (@(posedge i_clock) disable iff (i_rst) edge_event);
  COV_GATED: cover property (@(posedge i_clock) disable iff (i_rst)
    accum_mode_sel && count_step);
  COV_IRQ: cover property (@(posedge i_clock) disable iff (i_rst) $rose(o_irq));

endmodule : pac_top

// *** pac_top_test.sv ***
// Self-checking bench for the pulse accumulator.
// Assumes the register port of pac_top and the pin model pac_pin_src.
`timescale 1ns/1ps
module pac_top_test;
  import pac_pkg::*;
  localparam int DIV = 8; // Short gate period keeps the run brief
  logic i_clock;
  logic i_rst;
  logic i_wr;
  logic i_rd;
  logic o_irq;
  logic pin;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic [7:0] o_rdata;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  pac_top #(.GATE_DIV(DIV)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_accum_input_pin(pin), .o_irq(o_irq));
  pac_pin_src src (.i_clock(i_clock), .o_pin(pin));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the main sequence or the hang guard
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  // Hang guard; the tests need under 3000 cycles
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t timeout", $time);
      give_verdict();
    end
  end

  // Byte compare; a range allows for the free-running gate phase
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    logic ok;
    ok = (lo == hi) ? (got === lo) : ((got >= lo && got <= hi) === 1'b1);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH t=%0t byte %h not in %h..%h", $time, got, lo, hi);
    end
  endtask : chk_byte

  // Interrupt compare after the flag and output registers settle
  task automatic chk_irq(input logic exp);
    repeat (3) @(posedge i_clock);
    #1;
    samples_checked++;
    if (o_irq !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t irq %b", $time, o_irq);
    end
  endtask : chk_irq

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk_byte(o_rdata, lo, hi);
  endtask : rd

  task automatic pulses(input int n);
    repeat (n) src.pulse(6, 6);
    repeat (8) @(posedge i_clock);
  endtask : pulses

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(PAC_OFS_MASK, 8'h00, 8'h00);
    rd(PAC_OFS_FLAG, 8'h00, 8'h00);
    rd(PAC_OFS_CTRL, 8'h00, 8'h00);
    rd(8'h30, 8'h00, 8'h00);
    wr(PAC_OFS_MASK, 8'hff);
    rd(PAC_OFS_MASK, 8'h30, 8'h30);
    wr(PAC_OFS_MASK, 8'h00);
    wr(PAC_OFS_CTRL, 8'hff);
    rd(PAC_OFS_CTRL, 8'h70, 8'h70);
    wr(PAC_OFS_CTRL, 8'h00);
    wr(PAC_OFS_COUNT, 8'h5a);
    rd(PAC_OFS_COUNT, 8'h5a, 8'h5a);
    $display("test registers done");
    // Disabled: edges neither count nor flag
    pulses(3);
    rd(PAC_OFS_COUNT, 8'h5a, 8'h5a);
    rd(PAC_OFS_FLAG, 8'h00, 8'h00);
    $display("test disabled done");
    // Event mode, falling edges
    wr(PAC_OFS_CTRL, 8'h40);
    wr(PAC_OFS_COUNT, 8'h00);
    pulses(3);
    rd(PAC_OFS_COUNT, 8'h03, 8'h03);
    rd(PAC_OFS_FLAG, 8'h10, 8'h10);
    wr(PAC_OFS_FLAG, 8'h10);
    rd(PAC_OFS_FLAG, 8'h00, 8'h00);
    $display("test falling done");
    // Event mode, rising edges across the roll to zero
    wr(PAC_OFS_CTRL, 8'h50);
    wr(PAC_OFS_COUNT, 8'hfe);
    pulses(2);
    rd(PAC_OFS_COUNT, 8'h00, 8'h00);
    rd(PAC_OFS_FLAG, 8'h30, 8'h30);
    chk_irq(1'b0);
    wr(PAC_OFS_MASK, 8'h20);
    chk_irq(1'b1);
    wr(PAC_OFS_FLAG, 8'h20);
    chk_irq(1'b0);
    rd(PAC_OFS_FLAG, 8'h10, 8'h10);
    wr(PAC_OFS_MASK, 8'h10);
    chk_irq(1'b1);
    wr(PAC_OFS_FLAG, 8'h10);
    chk_irq(1'b0);
    $display("test overflow done");
    // Gated mode: ten gate periods, both edge bits, inhibit checked with edge bit 0 and pin low only
    wr(PAC_OFS_MASK, 8'h00);
    src.hold(1'b1, 10);
    wr(PAC_OFS_CTRL, 8'h60);
    wr(PAC_OFS_COUNT, 8'h00);
    repeat (10 * DIV) @(posedge i_clock);
    rd(PAC_OFS_COUNT, 8'h09, 8'h0b);
    src.hold(1'b0, 10);
    wr(PAC_OFS_COUNT, 8'h00);
    repeat (10 * DIV) @(posedge i_clock);
    rd(PAC_OFS_COUNT, 8'h00, 8'h00);
    wr(PAC_OFS_CTRL, 8'h70);
    wr(PAC_OFS_COUNT, 8'h00);
    repeat (10 * DIV) @(posedge i_clock);
    rd(PAC_OFS_COUNT, 8'h09, 8'h0b);
    rd(PAC_OFS_FLAG, 8'h10, 8'h10);
    $display("test gated done");
    // Reset in mid-run clears count, control and flags
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(PAC_OFS_COUNT, 8'h00, 8'h00);
    rd(PAC_OFS_CTRL, 8'h00, 8'h00);
    rd(PAC_OFS_FLAG, 8'h00, 8'h00);
    chk_irq(1'b0);
    $display("test reset done");
    give_verdict();
  end
endmodule : pac_top_test
